/* design/ipv_pkg.sv */
// package of the interrupt prioritizer: register map, source layout, vector table
// assumes one clock at 200 MHz and a core that marks machine-cycle phases
package ipv_pkg;

    // ****************************************
    // register map
    // ****************************************
    localparam logic [7:0] ADDR_ENABLE_PRIMARY = 8'ha8;
    localparam logic [7:0] ADDR_PRIORITY_PRIMARY = 8'hb8;
    localparam logic [7:0] ADDR_STATUS = 8'hb9;
    localparam logic [7:0] ADDR_ENABLE_TIMER2 = 8'he8;
    localparam logic [7:0] ADDR_PRIORITY_TIMER2 = 8'hf8;
    localparam logic [7:0] RST_ENABLE = 8'h00;
    localparam logic [7:0] RST_PRIORITY = 8'h00;
    localparam logic [7:0] PRIO_PRIMARY_MASK = 8'h7f;
    localparam int GLOBAL_GATE_BIT = 7;

    // ****************************************
    // sources, indexed in vector order
    // ****************************************
    localparam int NSRC = 15;
    localparam int SRC_EXT0 = 0;
    localparam int SRC_TIMER0 = 1;
    localparam int SRC_EXT1 = 2;
    localparam int SRC_TIMER1 = 3;
    localparam logic [15:0] VECTOR_BASE = 16'h0003;
    localparam int VECTOR_STEP_SHIFT = 3;
    localparam logic [3:0] IDX_NONE = 4'hf;

    // poll order, highest first, as source indices
    localparam logic [3:0] POLL_ORDER [NSRC] = '{
        4'h0, 4'h5, 4'ha, 4'h1, 4'h6, 4'hb, 4'h2, 4'h7,
        4'hc, 4'h3, 4'h8, 4'hd, 4'h4, 4'h9, 4'he
    };

    typedef enum logic [2:0] {
        IPV_IDLE,
        IPV_PUSH_LO,
        IPV_PUSH_HI,
        IPV_POP_HI,
        IPV_POP_LO,
        IPV_RET_CAP
    } ipv_seq_t;

endpackage

/* design/ipv_prioritizer.sv */
// two-level fifteen-source interrupt prioritizer with hardware call sequencer
// assumes request flags, phase strobes and stack port come from same-clock core logic
//
// Operation
// - poll samples taken at previous S5P2
// - blocked requests are not remembered
// - acknowledge forces hardware long call
// - vectoring clears timer0, timer1 and external flags
// - external flag cleared only in edge mode
// - call pushes pc only, loads vector
// - return clears active priority level
// - return pops two bytes into pc
// - global gate blocks or allows all
// - primary enable register layout at a8
// - timer2 enable register layout at e8
// - enable bit zero disables, one enables
// - primary priority mirrors enable, bit7 reserved
// - timer2 priority register layout at f8
// - high preempts low, high never preempted
// - block on active level, midinstruction, after return/access
// - fixed poll order within one level
// - vectors from 0003 in steps of eight
//
// The address-and-strobe port is this design's own decision.
module ipv_prioritizer (
    input wire logic ref_clk_i,
    input wire logic rst_b_i,
    input wire logic ce_i,
    input wire logic [7:0] reg_addr_i,
    input wire logic [7:0] reg_wdata_i,
    input wire logic reg_we_i,
    input wire logic reg_re_i,
    output logic [7:0] reg_rdata_o,
    input wire logic [14:0] req_flag_i,
    input wire logic [1:0] ext_edge_mode_i,
    input wire logic s5p2_i,
    input wire logic instr_final_i,
    input wire logic return_from_interrupt_i,
    input wire logic [15:0] pc_i,
    input wire logic [7:0] pop_data_i,
    output logic hardware_long_call_o,
    output logic stack_push_o,
    output logic stack_pop_o,
    output logic [7:0] stack_data_o,
    output logic pc_load_o,
    output logic [15:0] pc_value_o,
    output logic [3:0] flag_clear_o
);

    // ****************************************
    // state
    // ****************************************
    typedef struct packed {
        logic [7:0] enable_primary;
        logic [7:0] enable_timer2;
        logic [7:0] priority_primary;
        logic [7:0] priority_timer2;
        logic [14:0] sample;
        logic act_hi;
        logic act_lo;
        logic block_next;
        ipv_pkg::ipv_seq_t seq;
        logic [15:0] vector;
        logic [7:0] ret_hi;
        logic [3:0] last_src;
        logic [7:0] rdata;
        logic call;
        logic push;
        logic pop;
        logic [7:0] sdata;
        logic pc_load;
        logic [15:0] pc_value;
        logic [3:0] clr;
    } ipv_state_t;

    ipv_state_t st_reg;
    ipv_state_t st_next;

    logic [14:0] src_en;
    logic [14:0] src_lvl;
    logic [14:0] eligible;
    logic [3:0] win_hi;
    logic [3:0] win_lo;
    logic [3:0] win;
    logic take;

    // ****************************************
    // source mapping in vector order
    // ****************************************
    always_comb begin
        src_en = {st_reg.enable_timer2[7], st_reg.enable_timer2[6:4],
                  st_reg.enable_primary[6], st_reg.enable_timer2[3:0],
                  st_reg.enable_primary[5:0]};
        src_lvl = {st_reg.priority_timer2[7], st_reg.priority_timer2[6:4],
                   st_reg.priority_primary[6], st_reg.priority_timer2[3:0],
                   st_reg.priority_primary[5:0]};
    end

    // ****************************************
    // polling and arbitration
    // ****************************************
    always_comb begin
        eligible = st_reg.sample & src_en & {15{st_reg.enable_primary[ipv_pkg::GLOBAL_GATE_BIT]}};
        win_hi = ipv_pkg::IDX_NONE;
        win_lo = ipv_pkg::IDX_NONE;
        // walk lowest to highest so the earliest in poll order wins
        for (int k = ipv_pkg::NSRC - 1; k >= 0; k--) begin
            if (eligible[ipv_pkg::POLL_ORDER[k]] && src_lvl[ipv_pkg::POLL_ORDER[k]]) begin
                win_hi = ipv_pkg::POLL_ORDER[k];
            end
            if (eligible[ipv_pkg::POLL_ORDER[k]] && !src_lvl[ipv_pkg::POLL_ORDER[k]]) begin
                win_lo = ipv_pkg::POLL_ORDER[k];
            end
        end
        if (win_hi != ipv_pkg::IDX_NONE && !st_reg.act_hi) begin
            win = win_hi;
        end else if (win_lo != ipv_pkg::IDX_NONE && !st_reg.act_hi && !st_reg.act_lo) begin
            win = win_lo;
        end else begin
            win = ipv_pkg::IDX_NONE;
        end
        take = s5p2_i && instr_final_i && !st_reg.block_next && !return_from_interrupt_i
            && st_reg.seq == ipv_pkg::IPV_IDLE && win != ipv_pkg::IDX_NONE;
    end

    // ****************************************
    // next state
    // ****************************************
    always_comb begin
        st_next = st_reg;
        st_next.call = 1'b0;
        st_next.push = 1'b0;
        st_next.pop = 1'b0;
        st_next.pc_load = 1'b0;
        st_next.clr = 4'h0;

        // register port
        if (reg_we_i) begin
            case (reg_addr_i)
                ipv_pkg::ADDR_ENABLE_PRIMARY: st_next.enable_primary = reg_wdata_i;
                ipv_pkg::ADDR_ENABLE_TIMER2: st_next.enable_timer2 = reg_wdata_i;
                ipv_pkg::ADDR_PRIORITY_PRIMARY: begin
                    st_next.priority_primary = reg_wdata_i & ipv_pkg::PRIO_PRIMARY_MASK;
                end
                ipv_pkg::ADDR_PRIORITY_TIMER2: st_next.priority_timer2 = reg_wdata_i;
                default: ;
            endcase
        end
        st_next.rdata = 8'h00;
        if (reg_re_i) begin
            case (reg_addr_i)
                ipv_pkg::ADDR_ENABLE_PRIMARY: st_next.rdata = st_reg.enable_primary;
                ipv_pkg::ADDR_ENABLE_TIMER2: st_next.rdata = st_reg.enable_timer2;
                ipv_pkg::ADDR_PRIORITY_PRIMARY: st_next.rdata = st_reg.priority_primary;
                ipv_pkg::ADDR_PRIORITY_TIMER2: st_next.rdata = st_reg.priority_timer2;
                ipv_pkg::ADDR_STATUS: begin
                    st_next.rdata = {2'h0, st_reg.act_hi, st_reg.act_lo, st_reg.last_src};
                end
                default: st_next.rdata = 8'h00;
            endcase
        end

        // one instruction of grace after an access or a return
        if (s5p2_i && instr_final_i) begin
            st_next.block_next = 1'b0;
        end
        if (return_from_interrupt_i || ((reg_we_i || reg_re_i)
            && (reg_addr_i == ipv_pkg::ADDR_ENABLE_PRIMARY
            || reg_addr_i == ipv_pkg::ADDR_ENABLE_TIMER2
            || reg_addr_i == ipv_pkg::ADDR_PRIORITY_PRIMARY
            || reg_addr_i == ipv_pkg::ADDR_PRIORITY_TIMER2))) begin
            st_next.block_next = 1'b1;
        end

        // fresh sample each machine cycle, nothing kept
        if (s5p2_i) begin
            st_next.sample = req_flag_i;
        end

        // acknowledge
        if (take) begin
            st_next.call = 1'b1;
            st_next.last_src = win;
            st_next.vector = ipv_pkg::VECTOR_BASE
                + 16'({12'h000, win} << ipv_pkg::VECTOR_STEP_SHIFT);
            if (src_lvl[win]) begin
                st_next.act_hi = 1'b1;
            end else begin
                st_next.act_lo = 1'b1;
            end
            // other flags left for software
            case (win)
                4'(ipv_pkg::SRC_EXT0): st_next.clr[ipv_pkg::SRC_EXT0] = ext_edge_mode_i[0];
                4'(ipv_pkg::SRC_TIMER0): st_next.clr[ipv_pkg::SRC_TIMER0] = 1'b1;
                4'(ipv_pkg::SRC_EXT1): st_next.clr[ipv_pkg::SRC_EXT1] = ext_edge_mode_i[1];
                4'(ipv_pkg::SRC_TIMER1): st_next.clr[ipv_pkg::SRC_TIMER1] = 1'b1;
                default: ;
            endcase
            st_next.seq = ipv_pkg::IPV_PUSH_LO;
            st_next.push = 1'b1;
            st_next.sdata = pc_i[7:0];
        end

        // call and return sequencer
        case (st_reg.seq)
            ipv_pkg::IPV_IDLE: begin
                if (return_from_interrupt_i && !take) begin
                    if (st_reg.act_hi) begin
                        st_next.act_hi = 1'b0;
                    end else begin
                        st_next.act_lo = 1'b0;
                    end
                    st_next.seq = ipv_pkg::IPV_POP_HI;
                    st_next.pop = 1'b1;
                end
            end
            // pc pushed low then high, status word not saved
            ipv_pkg::IPV_PUSH_LO: begin
                st_next.push = 1'b1;
                st_next.sdata = pc_i[15:8];
                st_next.seq = ipv_pkg::IPV_PUSH_HI;
            end
            ipv_pkg::IPV_PUSH_HI: begin
                st_next.pc_load = 1'b1;
                st_next.pc_value = st_reg.vector;
                st_next.seq = ipv_pkg::IPV_IDLE;
            end
            // two pops, high byte first
            ipv_pkg::IPV_POP_HI: begin
                st_next.pop = 1'b1;
                st_next.seq = ipv_pkg::IPV_POP_LO;
            end
            ipv_pkg::IPV_POP_LO: begin
                st_next.ret_hi = pop_data_i;
                st_next.seq = ipv_pkg::IPV_RET_CAP;
            end
            ipv_pkg::IPV_RET_CAP: begin
                st_next.pc_load = 1'b1;
                st_next.pc_value = {st_reg.ret_hi, pop_data_i};
                st_next.seq = ipv_pkg::IPV_IDLE;
            end
            default: st_next.seq = ipv_pkg::IPV_IDLE;
        endcase
    end

    // ****************************************
    // registers
    // ****************************************
    always_ff @(posedge ref_clk_i) begin
        if (!rst_b_i) begin
            st_reg <= '0;
            st_reg.enable_primary <= ipv_pkg::RST_ENABLE;
            st_reg.enable_timer2 <= ipv_pkg::RST_ENABLE;
            st_reg.priority_primary <= ipv_pkg::RST_PRIORITY;
            st_reg.priority_timer2 <= ipv_pkg::RST_PRIORITY;
            st_reg.seq <= ipv_pkg::IPV_IDLE;
            st_reg.last_src <= ipv_pkg::IDX_NONE;
        end else if (ce_i) begin
            st_reg <= st_next;
        end
    end

    assign reg_rdata_o = st_reg.rdata;
    assign hardware_long_call_o = st_reg.call;
    assign stack_push_o = st_reg.push;
    assign stack_pop_o = st_reg.pop;
    assign stack_data_o = st_reg.sdata;
    assign pc_load_o = st_reg.pc_load;
    assign pc_value_o = st_reg.pc_value;
    assign flag_clear_o = st_reg.clr;

endmodule

/* bench/ipv_prioritizer_chk.sv */
// checker of call, return and read timing of the prioritizer
// assumes one clock and the synchronous active-low reset
module ipv_prioritizer_chk (
    input wire logic ref_clk_i,
    input wire logic rst_b_i,
    input wire logic [7:0] reg_addr_i,
    input wire logic reg_re_i,
    input wire logic [7:0] reg_rdata_o,
    input wire logic [1:0] ext_edge_mode_i,
    input wire logic s5p2_i,
    input wire logic instr_final_i,
    input wire logic return_from_interrupt_i,
    input wire logic [15:0] pc_i,
    input wire logic [7:0] pop_data_i,
    input wire logic hardware_long_call_o,
    input wire logic stack_push_o,
    input wire logic stack_pop_o,
    input wire logic [7:0] stack_data_o,
    input wire logic pc_load_o,
    input wire logic [15:0] pc_value_o,
    input wire logic [3:0] flag_clear_o
);
    timeunit 1ns;
    timeprecision 100ps;
    // ****************
    // properties
    // ****************
    default clocking @(posedge ref_clk_i);
    endclocking
    default disable iff (!rst_b_i);
    property p_seq;
        hardware_long_call_o |-> stack_push_o ##1 stack_push_o ##1 (pc_load_o && !stack_push_o);
    endproperty
    a_seq: assert property (p_seq) else $error("call sequence");
    property p_vec;
        hardware_long_call_o |-> ##2 pc_value_o[2:0] == 3'h3 && pc_value_o[15:7] == 9'h0;
    endproperty
    a_vec: assert property (p_vec) else $error("vector address");
    property p_pc;
        hardware_long_call_o |-> {8'h00, stack_data_o} == ($past(pc_i) & 16'h00ff)
            ##1 {8'h00, stack_data_o} == ($past(pc_i) >> 8);
    endproperty
    a_pc: assert property (p_pc) else $error("pushed pc");
    property p_take;
        hardware_long_call_o |-> $past(s5p2_i) && $past(instr_final_i);
    endproperty
    a_take: assert property (p_take) else $error("call off poll");
    property p_ret;
        return_from_interrupt_i && !stack_push_o && !stack_pop_o && !$past(stack_pop_o)
            && !pc_load_o |=> stack_pop_o [*2] ##1 !stack_pop_o ##1 pc_load_o;
    endproperty
    a_ret: assert property (p_ret) else $error("return pops");
    property p_pop;
        $fell(stack_pop_o) |=> pc_value_o == {$past(pop_data_i, 2), $past(pop_data_i)};
    endproperty
    a_pop: assert property (p_pop) else $error("popped pc");
    property p_rsv;
        $past(reg_re_i) && $past(reg_addr_i) == ipv_pkg::ADDR_PRIORITY_PRIMARY |-> !reg_rdata_o[7];
    endproperty
    a_rsv: assert property (p_rsv) else $error("reserved bit");
    property p_clr;
        |flag_clear_o |-> hardware_long_call_o && $onehot(flag_clear_o)
            && ({flag_clear_o[2], flag_clear_o[0]} & ~$past(ext_edge_mode_i)) == 2'h0;
    endproperty
    a_clr: assert property (p_clr) else $error("flag clear");
endmodule

bind ipv_prioritizer ipv_prioritizer_chk i_ipv_prioritizer_chk (.ref_clk_i, .rst_b_i,
    .reg_addr_i, .reg_re_i, .reg_rdata_o, .ext_edge_mode_i, .s5p2_i, .instr_final_i,
    .return_from_interrupt_i, .pc_i, .pop_data_i, .hardware_long_call_o, .stack_push_o,
    .stack_pop_o, .stack_data_o, .pc_load_o, .pc_value_o, .flag_clear_o);

/* bench/ipv_core_model.sv */
// core model: machine-cycle phases, fixed pc and a small stack
// assumes the prioritizer's stack port timing on the same clock
module ipv_core_model #(
    parameter logic [15:0] PC = 16'h5a3c
) (
    input wire logic clk_i,
    input wire logic rst_b_i,
    input wire logic push_i,
    input wire logic pop_i,
    input wire logic [7:0] data_i,
    output logic s5p2_o,
    output logic final_o,
    output logic [15:0] pc_o,
    output logic [7:0] pop_data_o
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [7:0] mem_reg [4];
    logic [1:0] sp_reg;
    logic [2:0] ph_reg;
    assign pc_o = PC;
    // six clocks a machine cycle, every second one ends an instruction
    always @(posedge clk_i) begin
        ph_reg <= (!rst_b_i || ph_reg == 3'h5) ? 3'h0 : ph_reg + 3'h1;
        s5p2_o <= rst_b_i && ph_reg == 3'h3;
        final_o <= rst_b_i && (ph_reg == 3'h5 ? !final_o : final_o);
        if (push_i) mem_reg[sp_reg] <= data_i;
        sp_reg <= !rst_b_i ? 2'h0 : sp_reg + {1'b0, push_i} - {1'b0, pop_i};
        // idle byte shows the inverse, not the last value
        pop_data_o <= !rst_b_i ? 8'h00 : pop_i ? mem_reg[sp_reg - 2'h1] : ~pop_data_o;
    end
endmodule

/* bench/test_ipv_prioritizer.sv */
// self-checking bench of the prioritizer against the core model
// assumes the package, design, checker and core model compiled first
module test_ipv_prioritizer;
    timeunit 1ns;
    timeprecision 100ps;
    localparam logic [59:0] ORD = 60'h05a16b27c38d49e;
    logic ref_clk_i = 1'b0;
    logic rst_b_i = 1'b0;
    logic we = 1'b0, re = 1'b0, ret = 1'b0, re_d = 1'b0, s5, fin, call, psh, pop, ld;
    logic [7:0] ad = 8'h00, wd = 8'h00, rdat, sd, pd;
    logic [14:0] req = 15'h0;
    logic [15:0] pc, pv;
    logic [3:0] clr, clr_s = 4'h0, s;
    logic [1:0] em = 2'b01;
    logic ce = 1'b1;
    logic [7:0] ar [4] = '{8'ha8, ipv_pkg::ADDR_PRIORITY_PRIMARY, 8'he8, 8'hf8};
    logic [31:0] rnd = 32'h23088074;
    logic [7:0] rq[$];
    logic [19:0] vq[$];
    int n_errors = 0, tests_run = 0, cyc = 0;
    always #2.5 ref_clk_i = ~ref_clk_i;
    ipv_prioritizer i_ipv_prioritizer (
        .ref_clk_i(ref_clk_i), .rst_b_i(rst_b_i), .ce_i(ce), .reg_addr_i(ad),
        .reg_wdata_i(wd), .reg_we_i(we), .reg_re_i(re), .reg_rdata_o(rdat),
        .req_flag_i(req), .ext_edge_mode_i(em), .s5p2_i(s5), .instr_final_i(fin),
        .return_from_interrupt_i(ret), .pc_i(pc), .pop_data_i(pd),
        .hardware_long_call_o(call), .stack_push_o(psh), .stack_pop_o(pop),
        .stack_data_o(sd), .pc_load_o(ld), .pc_value_o(pv), .flag_clear_o(clr));
    ipv_core_model i_ipv_core_model (.clk_i(ref_clk_i), .rst_b_i(rst_b_i), .push_i(psh),
        .pop_i(pop), .data_i(sd), .s5p2_o(s5), .final_o(fin), .pc_o(pc), .pop_data_o(pd));
    // ****************
    // tasks
    // ****************
    function automatic logic [31:0] xs(input logic [31:0] x);
        x = x ^ (x << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction
    task automatic chk(input logic [19:0] g, input logic [19:0] e);
        tests_run++;
        if (g !== e) begin
            n_errors++;
            $display("ERROR %0t: got %h want %h", $time, g, e);
        end
    endtask
    task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
        @(posedge ref_clk_i);
        if (!w) rq.push_back(d);
        ad <= a;
        wd <= d;
        we <= w;
        re <= !w;
        @(posedge ref_clk_i);
        we <= 1'b0;
        re <= 1'b0;
    endtask
    task automatic wld(input logic [19:0] e);
        vq.push_back(e);
        for (int k = 0; k < 400 && !ld; k++) @(posedge ref_clk_i);
        @(posedge ref_clk_i);
    endtask
    task automatic rti();
        @(posedge ref_clk_i);
        ret <= 1'b1;
        @(posedge ref_clk_i);
        ret <= 1'b0;
        wld({4'h0, 16'h5a3c});
    endtask
    task automatic idle();
        repeat (60) @(posedge ref_clk_i);
    endtask
    task automatic end_sim();
        n_errors += vq.size();
        $display("checks %0d, mismatches %0d", tests_run, n_errors);
        if (n_errors == 0 && tests_run > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    // ****************
    // watcher and sequence
    // ****************
    always @(posedge ref_clk_i) begin
        cyc <= cyc + 1;
        re_d <= re;
        if (call || ret) clr_s <= clr;
        if (re_d) chk({12'h0, rdat}, {12'h0, rq.pop_front()});
        if (ld) chk({clr_s, pv}, vq.size() > 0 ? vq.pop_front() : 20'hxxxxx);
        if (cyc == 10000) begin
            n_errors++;
            end_sim();
        end
    end
    initial begin
        logic [7:0] v;
        repeat (20) @(posedge ref_clk_i);
        rst_b_i <= 1'b1;
        foreach (ar[i]) bus(1'b0, ar[i], 8'h00);
        bus(1'b0, 8'h10, 8'h00);
        foreach (ar[i]) begin
            v = rnd[7:0];
            rnd = xs(rnd);
            bus(1'b1, ar[i], v);
            bus(1'b0, ar[i], i == 1 ? v & 8'h7f : v);
        end
        $display("register test done");
        bus(1'b1, 8'he8, 8'hff);
        bus(1'b1, 8'ha8, 8'h7f);
        bus(1'b1, ar[1], 8'h00);
        bus(1'b1, 8'hf8, 8'h00);
        req <= 15'h7fff;
        idle();
        bus(1'b1, 8'he8, 8'h00);
        bus(1'b1, 8'ha8, 8'h80);
        idle();
        req <= 15'h0;
        bus(1'b1, 8'he8, 8'hff);
        bus(1'b1, 8'ha8, 8'hff);
        idle();
        $display("gating test done");
        req <= 15'h7fff;
        for (int k = 0; k < 15; k++) begin
            s = ORD[59 - 4 * k -: 4];
            wld({(s < 4 && s != 2) ? 4'h1 << s : 4'h0, 9'h0, s, 3'h3});
            req[s] <= 1'b0;
            rti();
        end
        $display("poll order test done");
        bus(1'b1, ar[1], 8'h08);
        bus(1'b1, 8'hf8, 8'h80);
        req <= 15'h0001;
        wld({4'h1, 16'h0003});
        req <= 15'h0008;
        wld({4'h8, 16'h001b});
        req <= 15'h4000;
        idle();
        rti();
        wld({4'h0, 16'h0073});
        req <= 15'h0;
        rti();
        rti();
        bus(1'b0, ipv_pkg::ADDR_STATUS, 8'h0e);
        $display("nesting test done");
        ce <= 1'b0;
        bus(1'b1, 8'he8, 8'h55);
        ce <= 1'b1;
        bus(1'b0, 8'he8, 8'hff);
        $display("enable test done");
        end_sim();
    end
endmodule
